// ### verilog/aout_ctrl.sv
// top: two-channel analog output control with avalon-mm register slave
`timescale 1ns/1ps
module aout_ctrl #(
   parameter int CYC_1MS   = aout_pkg::CYC_1MS_N,
   parameter int NCH       = 2
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [15:0] dac_code0,
   output logic      [15:0] dac_code1,
   output logic             dac_load
);

   // ****************************************
   // registers
   // ****************************************
   logic        [31:0] ctrl_q, ctrl_d;
   logic        [7:0]  cfg_q [NCH], cfg_d [NCH];
   logic signed [15:0] set_q [NCH], set_d [NCH];
   logic signed [15:0] ulim_q, ulim_d, llim_q, llim_d;
   logic signed [15:0] ratio_q, ratio_d, bias_q, bias_d, ain_q, ain_d;
   logic               run_q, run_d;
   logic               lim_err_q, lim_err_d;
   logic        [31:0] rdata_q, rdata_d;
   logic               ack_q, ack_d;
   logic        [15:0] tmr_q, tmr_d;
   logic               pend_q, pend_d;
   logic signed [15:0] use_q [NCH], use_d [NCH];
   logic               load_q, load_d;
   logic        [15:0] dac0_q, dac0_d, dac1_q, dac1_d;
   logic        [7:0]  cfg_eff [NCH];
   logic signed [15:0] in_span;
   logic               clamped [NCH];
   logic signed [15:0] code [NCH];
   logic        [15:0] period;
   logic               req;
   logic               hold [NCH];
   logic               tick;

   aout_chan_if chif [NCH] ();

   // ****************************************
   // conversion cycle selection
   // ****************************************
   always_comb begin
      unique case (ctrl_q[aout_pkg::CTRL_CYC_LO +: 2])
         aout_pkg::CYC_500US: period = 16'(CYC_1MS / 2);
         aout_pkg::CYC_250US: period = 16'(CYC_1MS / 4);
         default:             period = 16'(CYC_1MS);
      endcase
      tick = (tmr_q == 16'h0000);
   end

   // ****************************************
   // bus slave and register writes
   // ****************************************
   always_comb begin
      // one wait state: the ack flop answers the cycle after the request
      req       = (avs_read || avs_write) && !ack_q;
      ack_d     = req;
      ctrl_d    = ctrl_q;
      cfg_d     = cfg_q;
      set_d     = set_q;
      ulim_d    = ulim_q;
      llim_d    = llim_q;
      ratio_d   = ratio_q;
      bias_d    = bias_q;
      ain_d     = ain_q;
      run_d     = ctrl_q[aout_pkg::CTRL_RUN];
      // the tick latches pending data; a write in that cycle sets it again
      pend_d    = tick ? 1'b0 : pend_q;
      lim_err_d = lim_err_q;
      if (avs_write && req) begin
         unique case (avs_address)
            aout_pkg::OFS_CTRL:  ctrl_d = avs_writedata;
            aout_pkg::OFS_CFG0:  cfg_d[0] = avs_writedata[7:0];
            aout_pkg::OFS_CFG1:  cfg_d[1] = avs_writedata[7:0];
            aout_pkg::OFS_SET0:  set_d[0] = avs_writedata[15:0];
            aout_pkg::OFS_SET1:  set_d[1] = avs_writedata[15:0];
            aout_pkg::OFS_ULIM:  ulim_d = avs_writedata[15:0];
            aout_pkg::OFS_LLIM:  llim_d = avs_writedata[15:0];
            // ratio is in hundredths, clipped to its top value
            aout_pkg::OFS_RATIO: ratio_d = (avs_writedata[15:0] >
                                   16'(aout_pkg::RATIO_MAX)) ?
                                   aout_pkg::RATIO_MAX : avs_writedata[15:0];
            aout_pkg::OFS_BIAS:  bias_d = avs_writedata[15:0];
            aout_pkg::OFS_AIN:   ain_d = avs_writedata[15:0];
            default:             ;
         endcase
         if (avs_address == aout_pkg::OFS_SET0 ||
             avs_address == aout_pkg::OFS_SET1) begin
            pend_d = 1'b1;
         end
      end
      // input values beyond the full span saturate instead of wrapping
      in_span = ctrl_q[aout_pkg::CTRL_HIRES] ? aout_pkg::SPAN_HI :
                aout_pkg::SPAN_LO;
      if (ain_d > in_span) begin
         ain_d = in_span;
      end else if (ain_d < -in_span) begin
         ain_d = -in_span;
      end
      // run to program transition drops both enables
      if (run_q && !ctrl_d[aout_pkg::CTRL_RUN]) begin
         ctrl_d[aout_pkg::CTRL_EN0] = 1'b0;
         ctrl_d[aout_pkg::CTRL_EN1] = 1'b0;
      end
      run_d = ctrl_d[aout_pkg::CTRL_RUN];
      lim_err_d = (ulim_d > aout_pkg::LIM_ABS) || (ulim_d < -aout_pkg::LIM_ABS)
                  || (llim_d > aout_pkg::LIM_ABS)
                  || (llim_d < -aout_pkg::LIM_ABS);
   end

   // ****************************************
   // register read-back
   // ****************************************
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (avs_read && req) begin
         unique case (avs_address)
            aout_pkg::OFS_CTRL:  rdata_d = ctrl_q;
            aout_pkg::OFS_CFG0:  rdata_d = {24'h000000, cfg_q[0]};
            aout_pkg::OFS_CFG1:  rdata_d = {24'h000000, cfg_q[1]};
            aout_pkg::OFS_SET0:  rdata_d = {16'h0000, set_q[0]};
            aout_pkg::OFS_SET1:  rdata_d = {16'h0000, set_q[1]};
            aout_pkg::OFS_ULIM:  rdata_d = {16'h0000, ulim_q};
            aout_pkg::OFS_LLIM:  rdata_d = {16'h0000, llim_q};
            aout_pkg::OFS_RATIO: rdata_d = {16'h0000, ratio_q};
            aout_pkg::OFS_BIAS:  rdata_d = {16'h0000, bias_q};
            aout_pkg::OFS_OUT0:  rdata_d = {16'h0000, code[0]};
            aout_pkg::OFS_OUT1:  rdata_d = {16'h0000, code[1]};
            aout_pkg::OFS_STAT:  rdata_d = {28'h0000000, lim_err_q,
                                            clamped[1], clamped[0], pend_q};
            aout_pkg::OFS_AIN:   rdata_d = {16'h0000, ain_q};
            default:             rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // conversion timer
   // ****************************************
   always_comb begin
      // the timer reloads at each tick, so a new cycle starts there
      tmr_d  = tick ? period - 16'h0001 : tmr_q - 16'h0001;
      load_d = tick;
   end

   // ****************************************
   // set data latch
   // ****************************************
   always_comb begin
      use_d = use_q;
      if (tick) begin
         // latched at one tick, converted at the next
         use_d = set_q;
      end
   end

   // ****************************************
   // hold decisions
   // ****************************************
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         hold[i] = !ctrl_q[i];
         if (ctrl_q[aout_pkg::CTRL_ADJ] &&
             (ctrl_q[aout_pkg::CTRL_ADJCH] != 1'(i))) begin
            hold[i] = 1'b1;
         end
         // a setting error holds only once the controller has stopped
         if (ctrl_q[aout_pkg::CTRL_STOP] && lim_err_q) begin
            hold[i] = 1'b1;
         end
      end
   end

   // ****************************************
   // scaling permission
   // ****************************************
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         cfg_eff[i] = cfg_q[i];
         // scaling runs only at the 1 ms cycle and the low resolution
         if ((ctrl_q[aout_pkg::CTRL_CYC_LO +: 2] != aout_pkg::CYC_1MS) ||
             ctrl_q[aout_pkg::CTRL_HIRES]) begin
            cfg_eff[i][aout_pkg::CFG_SCALE] = 1'b0;
         end
      end
   end

   // ****************************************
   // register file
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q    <= aout_pkg::CTRL_RESET;
         for (int i = 0; i < NCH; i++) begin
            cfg_q[i] <= aout_pkg::CFG_RESET;
            set_q[i] <= 16'sh0000;
            use_q[i] <= 16'sh0000;
         end
         ulim_q    <= 16'sh0000;
         llim_q    <= 16'sh0000;
         ratio_q   <= 16'sh0000;
         bias_q    <= 16'sh0000;
         ain_q     <= 16'sh0000;
         run_q     <= 1'b0;
         lim_err_q <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         ack_q     <= 1'b0;
         tmr_q     <= 16'h0000;
         pend_q    <= 1'b0;
         load_q    <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         cfg_q     <= cfg_d;
         set_q     <= set_d;
         ulim_q    <= ulim_d;
         llim_q    <= llim_d;
         ratio_q   <= ratio_d;
         bias_q    <= bias_d;
         ain_q     <= ain_d;
         run_q     <= run_d;
         lim_err_q <= lim_err_d;
         rdata_q   <= rdata_d;
         ack_q     <= ack_d;
         tmr_q     <= tmr_d;
         pend_q    <= pend_d;
         use_q     <= use_d;
         load_q    <= load_d;
      end
   end

   // ****************************************
   // channels
   // ****************************************
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign chif[g].cfg      = cfg_eff[g];
      assign chif[g].hires    = ctrl_q[aout_pkg::CTRL_HIRES];
      assign chif[g].hold_req = hold[g];
      assign chif[g].strobe   = tick;
      assign chif[g].setv     = use_q[g];
      assign chif[g].ain      = ain_q;
      assign chif[g].ulim     = ulim_q;
      assign chif[g].llim     = llim_q;
      assign chif[g].ratio    = ratio_q;
      assign chif[g].bias     = bias_q;
      assign code[g]          = chif[g].code;
      assign clamped[g]       = chif[g].clamped;
      aout_chan aout_chan_inst (
         .clk (clk),
         .rst (rst),
         .ch  (chif[g])
      );
   end

   // ****************************************
   // converter outputs
   // ****************************************
   always_comb begin
      dac0_d = code[0];
      dac1_d = code[1];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dac0_q <= 16'h0000;
         dac1_q <= 16'h0000;
      end else begin
         dac0_q <= dac0_d;
         dac1_q <= dac1_d;
      end
   end

   always_comb begin
      avs_readdata    = rdata_q;
      // waitrequest is the inverse of the ack flop
      avs_waitrequest = !ack_q;
      dac_code0       = dac0_q;
      dac_code1       = dac1_q;
      dac_load        = load_q;
   end

endmodule

// ### verilog/aout_pkg.sv
// package: register map, field layout, reset values and timing for the output block
package aout_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [5:0] OFS_CTRL      = 6'h00;
   localparam logic [5:0] OFS_CFG0      = 6'h04;
   localparam logic [5:0] OFS_CFG1      = 6'h08;
   localparam logic [5:0] OFS_SET0      = 6'h0c;
   localparam logic [5:0] OFS_SET1      = 6'h10;
   localparam logic [5:0] OFS_ULIM      = 6'h14;
   localparam logic [5:0] OFS_LLIM      = 6'h18;
   localparam logic [5:0] OFS_RATIO     = 6'h1c;
   localparam logic [5:0] OFS_BIAS      = 6'h20;
   localparam logic [5:0] OFS_OUT0      = 6'h24;
   localparam logic [5:0] OFS_OUT1      = 6'h28;
   localparam logic [5:0] OFS_STAT      = 6'h2c;
   localparam logic [5:0] OFS_AIN       = 6'h30;

   // ****************************************
   // control register fields
   // ****************************************
   localparam int CTRL_EN0    = 0;
   localparam int CTRL_EN1    = 1;
   localparam int CTRL_HIRES  = 2;
   localparam int CTRL_CYC_LO = 3;
   localparam int CTRL_ADJ    = 5;
   localparam int CTRL_ADJCH  = 6;
   localparam int CTRL_RUN    = 7;
   localparam int CTRL_STOP   = 8;

   // per-channel config fields
   localparam int CFG_RANGE_LO = 0;
   localparam int CFG_HOLD_LO  = 3;
   localparam int CFG_SCALE    = 5;
   localparam int CFG_RATIO    = 6;
   localparam int CFG_NEG      = 7;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [7:0]  CFG_RESET  = 8'h00;

   typedef enum logic [2:0] {
      RNG_1_5   = 3'b000,
      RNG_0_5   = 3'b001,
      RNG_0_10  = 3'b010,
      RNG_PM10  = 3'b011,
      RNG_4_20  = 3'b100
   } range_t;

   typedef enum logic [1:0] {
      HOLD_CLEAR = 2'b00,
      HOLD_KEEP  = 2'b01,
      HOLD_MAX   = 2'b10
   } hold_t;

   typedef enum logic [1:0] {
      CYC_1MS   = 2'b00,
      CYC_500US = 2'b01,
      CYC_250US = 2'b10
   } cycle_t;

   // ****************************************
   // code spans and limits
   // ****************************************
   localparam logic signed [15:0] SPAN_LO    = 16'sh0fa0;
   localparam logic signed [15:0] SPAN_HI    = 16'sh1f40;
   localparam logic signed [15:0] LIM_ABS    = 16'sh7d00;
   localparam logic signed [15:0] RATIO_MAX  = 16'sh270f;
   localparam logic signed [31:0] RATIO_ONE  = 32'sd100;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ       = 20_000_000;
   localparam int T_1MS_US     = 1000;
   localparam int T_500US_US   = 500;
   localparam int T_250US_US   = 250;
   localparam int CYC_1MS_N    = T_1MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_500US_N  = T_500US_US * (CLK_HZ / 1_000_000);
   localparam int CYC_250US_N  = T_250US_US * (CLK_HZ / 1_000_000);
   localparam int TASK_MIN     = 1;

endpackage

// ### verilog/aout_chan_if.sv
// interface: per-channel settings and results between top and channel datapath
`timescale 1ns/1ps
interface aout_chan_if;
   logic        [7:0]  cfg;
   logic               hires;
   logic               hold_req;
   logic               strobe;
   logic signed [15:0] setv;
   logic signed [15:0] ain;
   logic signed [15:0] ulim;
   logic signed [15:0] llim;
   logic signed [15:0] ratio;
   logic signed [15:0] bias;
   logic signed [15:0] code;
   logic               clamped;

   modport top  (output cfg, hires, hold_req, strobe, setv, ain, ulim, llim,
                 ratio, bias, input code, clamped);
   modport chan (input cfg, hires, hold_req, strobe, setv, ain, ulim, llim,
                 ratio, bias, output code, clamped);
endinterface

// ### verilog/aout_chan.sv
// module: one output channel datapath with ratio, scaling, clamp and hold
`timescale 1ns/1ps
module aout_chan (
   input  wire logic clk,
   input  wire logic rst,
   aout_chan_if.chan ch
);

   logic signed [15:0] code_q, code_d;
   logic               clamped_q, clamped_d;
   logic signed [31:0] span;
   logic signed [31:0] lo;
   logic signed [31:0] hi;
   logic signed [31:0] v;
   logic signed [31:0] num;
   logic signed [31:0] den;

   always_comb begin
      span      = ch.hires ? 32'(aout_pkg::SPAN_HI) : 32'(aout_pkg::SPAN_LO);
      lo        = 32'sd0;
      // bipolar range is centred on zero
      if (ch.cfg[aout_pkg::CFG_RANGE_LO +: 3] == aout_pkg::RNG_PM10) begin
         lo = -(span >>> 1);
      end
      hi        = lo + span;
      v         = 32'(ch.setv);
      num       = 32'sd0;
      den       = 32'sd1;
      code_d    = code_q;
      clamped_d = clamped_q;
      if (ch.cfg[aout_pkg::CFG_RATIO]) begin
         if (ch.cfg[aout_pkg::CFG_NEG]) begin
            v = hi - (32'(ch.ratio) * 32'(ch.ain)) / aout_pkg::RATIO_ONE
                + 32'(ch.bias);
         end else begin
            v = (32'(ch.ratio) * 32'(ch.ain)) / aout_pkg::RATIO_ONE
                + 32'(ch.bias);
         end
      end else if (ch.cfg[aout_pkg::CFG_SCALE] && !ch.hires) begin
         // user limits stand for the full span
         num = (32'(ch.setv) - 32'(ch.llim)) * span;
         den = 32'(ch.ulim) - 32'(ch.llim);
         if (den != 32'sd0) begin
            v = lo + num / den;
         end else begin
            v = lo;
         end
      end
      // hold states change only at the conversion tick, like set values
      if (ch.strobe && ch.hold_req) begin
         unique case (aout_pkg::hold_t'(ch.cfg[aout_pkg::CFG_HOLD_LO +: 2]))
            aout_pkg::HOLD_CLEAR: code_d = 16'(lo);
            aout_pkg::HOLD_MAX:   code_d = 16'(hi);
            default:              code_d = code_q;
         endcase
      end else if (ch.strobe) begin
         clamped_d = (v > hi) || (v < lo);
         if (v > hi) begin
            code_d = 16'(hi);
         end else if (v < lo) begin
            code_d = 16'(lo);
         end else begin
            code_d = 16'(v);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_q    <= 16'sh0000;
         clamped_q <= 1'b0;
      end else begin
         code_q    <= code_d;
         clamped_q <= clamped_d;
      end
   end

   assign ch.code    = code_q;
   assign ch.clamped = clamped_q;
endmodule

// ### verification/aout_host_model.sv
// avalon-mm master model standing in for the controller cpu
`timescale 1ns/1ps
module aout_host_model (
   input  wire logic        clk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic      [5:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata
);
   // ****************************************
   // bus cycle
   // ****************************************
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
   end

   // request held until waitrequest is sampled low; no wait limit here
   task automatic access(input logic wr, input logic [5:0] a,
                         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released lines must not keep showing the last value
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule

// ### verification/aout_ctrl_properties.sv
// concurrent checks on the ports of the analog output control top
`timescale 1ns/1ps
module aout_ctrl_checker #(
   parameter int CYC_1MS = 40
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [15:0] dac_code0,
   input wire logic [15:0] dac_code1,
   input wire logic        dac_load
);
   // ****************************************
   // properties
   // ****************************************
   logic unmapped;
   assign unmapped = (avs_address[1:0] != 2'h0) || (avs_address > 6'h30);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence req_s;
      avs_read || avs_write;
   endsequence
   sequence gap_s;
      !dac_load [*8];
   endsequence

   ack_after_req_a: assert property (req_s ##0 avs_waitrequest
      |=> !avs_waitrequest) else $error("no ack one cycle after request");
   ack_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   no_ack_idle_a: assert property (!avs_read && !avs_write
      |=> avs_waitrequest) else $error("ack without request");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest
      && unmapped |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   load_gap_a: assert property (dac_load |=> gap_s)
      else $error("conversion periods too close");
   code0_at_load_a: assert property ($changed(dac_code0)
      |-> dac_load || $past(dac_load))
      else $error("code0 changed between conversions");
   code1_at_load_a: assert property ($changed(dac_code1)
      |-> dac_load || $past(dac_load))
      else $error("code1 changed between conversions");
   code_bound_a: assert property (
      $signed(dac_code0) <= aout_pkg::SPAN_HI
      && $signed(dac_code0) >= -aout_pkg::SPAN_HI)
      else $error("code0 beyond full scale");
   code1_bound_a: assert property (
      $signed(dac_code1) <= aout_pkg::SPAN_HI
      && $signed(dac_code1) >= -aout_pkg::SPAN_HI)
      else $error("code1 beyond full scale");
   cover property (dac_load);
endmodule

bind aout_ctrl aout_ctrl_checker #(.CYC_1MS(CYC_1MS)) aout_ctrl_checker_inst (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .dac_code0(dac_code0), .dac_code1(dac_code1), .dac_load(dac_load));

// ### verification/analog_output_channel_control_bench.sv
// self-checking bench for the two-channel analog output control
`timescale 1ns/1ps
module analog_output_channel_control_bench;
   localparam int CYC = 40;
   logic        clk;
   logic        rst;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [15:0] dac_code0;
   logic [15:0] dac_code1;
   logic        dac_load;
   logic [31:0] rdv;
   int          miscompares;
   int          comparisons;

   aout_ctrl #(.CYC_1MS(CYC)) aout_ctrl_inst (
      .clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .dac_code0(dac_code0),
      .dac_code1(dac_code1), .dac_load(dac_load));
   aout_host_model aout_host_model_inst (
      .clk(clk), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      aout_host_model_inst.access(1'b1, a, {16'h0000, d}, rdv);
   endtask
   task automatic rd(input logic [5:0] a);
      aout_host_model_inst.access(1'b0, a, 32'h0000_0000, rdv);
   endtask
   // new set data needs a full period before it is converted
   task automatic see(input string what, input logic [15:0] e);
      repeat (3) @(posedge dac_load);
      repeat (2) @(posedge clk);
      chk(what, {16'h0000, e}, {16'h0000, dac_code0});
   endtask
   task automatic run0(input logic [7:0] cfg, input logic [15:0] ctl,
                       input logic [15:0] sv, input logic [15:0] e);
      wr(aout_pkg::OFS_CFG0, {8'h00, cfg});
      wr(aout_pkg::OFS_SET0, sv);
      wr(aout_pkg::OFS_CTRL, ctl);
      see("dac_code0", e);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd(aout_pkg::OFS_CTRL);
      chk("ctrl", aout_pkg::CTRL_RESET, rdv);
      rd(aout_pkg::OFS_CFG0);
      chk("cfg0", 32'h0000_0000, rdv);
      chk("dac_code0", 32'h0000_0000, {16'h0000, dac_code0});
      wr(6'h34, 16'hffff);
      rd(6'h34);
      chk("unmapped", 32'h0000_0000, rdv);
   endtask
   task automatic t_range;
      logic [7:0]  cf[7] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h00, 8'h04};
      logic [15:0] sv[7] = '{16'h03e8, 16'h1388, 16'hfffb, 16'h0bb8,
                             16'hf448, 16'h07d0, 16'h0fa1};
      logic [15:0] ex[7] = '{16'h03e8, 16'h0fa0, 16'h0000, 16'h07d0,
                             16'hf830, 16'h07d0, 16'h0fa0};
      for (int i = 0; i < 7; i++) begin
         run0(cf[i], 16'h0081, sv[i], ex[i]);
      end
   endtask
   task automatic t_delay;
      run0(8'h02, 16'h0081, 16'h03e8, 16'h03e8);
      wr(aout_pkg::OFS_SET0, 16'h07d0);
      @(posedge dac_load);
      repeat (2) @(posedge clk);
      chk("dac_code0", 32'h0000_03e8, {16'h0000, dac_code0});
      see("dac_code0", 16'h07d0);
   endtask
   task automatic t_hires;
      run0(8'h02, 16'h0085, 16'h2328, 16'h1f40);
      rd(aout_pkg::OFS_STAT);
      chk("status", 32'h0000_0002, {30'h0, rdv[1:0]});
      run0(8'h02, 16'h0085, 16'h1770, 16'h1770);
   endtask
   task automatic t_ch1;
      wr(aout_pkg::OFS_CFG1, 16'h0002);
      wr(aout_pkg::OFS_SET1, 16'h07d0);
      run0(8'h02, 16'h0082, 16'h03e8, 16'h0000);
      chk("dac_code1", 32'h0000_07d0, {16'h0000, dac_code1});
   endtask
   task automatic t_hold;
      logic [15:0] ex[3] = '{16'h0000, 16'h03e8, 16'h0fa0};
      for (int h = 0; h < 3; h++) begin
         run0({3'h0, h[1:0], 3'h2}, 16'h0081, 16'h03e8, 16'h03e8);
         run0({3'h0, h[1:0], 3'h2}, 16'h0080, 16'h0000, ex[h]);
      end
   endtask
   task automatic t_run_exit;
      run0(8'h12, 16'h0083, 16'h03e8, 16'h03e8);
      wr(aout_pkg::OFS_CTRL, 16'h0003);
      rd(aout_pkg::OFS_CTRL);
      chk("ctrl enables", 32'h0000_0000, {30'h0, rdv[1:0]});
      see("dac_code0", 16'h0fa0);
   endtask
   task automatic t_adj;
      wr(aout_pkg::OFS_CFG1, 16'h0012);
      wr(aout_pkg::OFS_SET1, 16'h03e8);
      run0(8'h02, 16'h00a3, 16'h03e8, 16'h03e8);
      chk("dac_code1", 32'h0000_0fa0, {16'h0000, dac_code1});
   endtask
   task automatic t_stop_err;
      wr(aout_pkg::OFS_ULIM, 16'h7d01);
      wr(aout_pkg::OFS_LLIM, 16'h0000);
      run0(8'h12, 16'h0181, 16'h03e8, 16'h0fa0);
      rd(aout_pkg::OFS_STAT);
      chk("limit error", 32'h0000_0001, {31'h0, rdv[3]});
      wr(aout_pkg::OFS_ULIM, 16'h07d0);
   endtask
   task automatic t_scale;
      run0(8'h22, 16'h0081, 16'h03e8, 16'h07d0);
      run0(8'h22, 16'h0085, 16'h03e8, 16'h03e8);
      run0(8'h22, 16'h0089, 16'h03e8, 16'h03e8);
   endtask
   task automatic t_ratio;
      wr(aout_pkg::OFS_AIN, 16'h01f4);
      wr(aout_pkg::OFS_RATIO, 16'h0064);
      wr(aout_pkg::OFS_BIAS, 16'h0064);
      run0(8'h42, 16'h0081, 16'h0000, 16'h0258);
      run0(8'hc2, 16'h0081, 16'h0000, 16'h0e10);
      wr(aout_pkg::OFS_AIN, 16'h7fff);
      rd(aout_pkg::OFS_AIN);
      chk("ain", 32'h0000_0fa0, rdv);
      wr(aout_pkg::OFS_AIN, 16'h8000);
      rd(aout_pkg::OFS_AIN);
      chk("ain", 32'h0000_f060, rdv);
   endtask
   task automatic t_period;
      realtime t0;
      for (int c = 0; c < 3; c++) begin
         wr(aout_pkg::OFS_CTRL, 16'h0081 | 16'(c << 3));
         repeat (2) @(posedge dac_load);
         t0 = $realtime;
         @(posedge dac_load);
         chk("period", CYC >> c, int'(($realtime - t0) / 50.0));
      end
   endtask

   task automatic tally_and_finish;
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (300 * CYC) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_range();
      t_delay();
      t_hires();
      t_ch1();
      t_hold();
      t_run_exit();
      t_adj();
      t_stop_err();
      t_scale();
      t_ratio();
      t_period();
      tally_and_finish();
   end
endmodule
